// ---- irq_core_model.sv ----
`timescale 1ns/10ps
// stands in for the core: vectors to whatever is offered while allowed
module irq_core_model (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       ack_en_in,
	input  wire logic       req_in,
	input  wire logic [3:0] vector_in,
	output logic            ack_out,
	output logic [3:0]      taken_vec_out,
	output logic [7:0]      taken_cnt_out
);
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_out       <= 1'b0;
			taken_vec_out <= 4'h0;
			taken_cnt_out <= 8'h00;
		end else begin
			// ack raised for one clock when req is seen while allowed, then dropped
			ack_out <= ack_en_in && req_in && !ack_out;
			if (ack_out && req_in) begin
				taken_vec_out <= vector_in;
				taken_cnt_out <= taken_cnt_out + 8'h01;
			end
		end
	end
endmodule : irq_core_model

// ---- irq_ext_if.sv ----
`timescale 1ns/10ps
interface irq_ext_if;
	logic pin;
	logic edge_sel;
	logic alt_sel;
	logic alt_event;
	logic tick;
	logic taken;
	logic flag;

	modport line (
		input  pin,
		input  edge_sel,
		input  alt_sel,
		input  alt_event,
		input  tick,
		input  taken,
		output flag
	);

	modport ctl (
		output pin,
		output edge_sel,
		output alt_sel,
		output alt_event,
		output tick,
		output taken,
		input  flag
	);
endinterface : irq_ext_if

// ---- irq_ext_line.sv ----
`timescale 1ns/10ps
`include "irq_regs.svh"
module irq_ext_line
	import irq_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic rst_in,
	irq_ext_if.line   ext
);
	logic meta;
	logic sync;
	logic samp;
	logic fall;

	// pin is asynchronous; meta feeds sync only
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta <= 1'b1;
			sync <= 1'b1;
		end else begin
			meta <= ext.pin;
			sync <= meta;
		end
	end

	// one sample per machine cycle; fall is a single-clock pulse
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			samp <= 1'b1;
			fall <= 1'b0;
		end else begin
			fall <= ext.tick & samp & ~sync;
			if (ext.tick) begin
				samp <= sync;
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ext.flag <= `IRQ_RESET_FLAG;
		end else if (ext.alt_sel) begin
			// converter owns the request, handled like a transition
			ext.flag <= ext.alt_event | (ext.flag & ~ext.taken);
		end else if (ext.edge_sel) begin
			ext.flag <= fall | (ext.flag & ~ext.taken);
		end else begin
			// level mode follows the line; vectoring leaves it alone
			ext.flag <= ~samp;
		end
	end

	a_edge_hw_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		ext.taken && ext.edge_sel && !ext.alt_sel && !fall |=> !ext.flag)
		else $error("transition flag not cleared on vectoring");

	a_level_holds_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		!ext.edge_sel && !ext.alt_sel && !samp ##1 !ext.edge_sel && !ext.alt_sel |-> ext.flag)
		else $error("level flag dropped while line held low");

	a_edge_sets_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		ext.tick && samp && !sync && ext.edge_sel && !ext.alt_sel
		##1 ext.edge_sel && !ext.alt_sel |=> ext.flag)
		else $error("falling sample did not set flag");
endmodule : irq_ext_line

// ---- irq_pkg.sv ----
package irq_pkg;
	`include "irq_regs.svh"

	typedef logic [`IRQ_NUM_SRC-1:0] irq_vec_type;
	typedef logic [3:0]              irq_idx_type;

	// nesting of routines in service: a low one may be preempted by a high one
	typedef enum logic [1:0] {
		SVC_IDLE,
		SVC_LOW,
		SVC_HIGH,
		SVC_LOW_HIGH
	} irq_svc_type;
endpackage : irq_pkg

// ---- irq_regs.svh ----
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

// number of request slots in the polling order
`define IRQ_NUM_SRC      10

// polling slots, 0 is polled first
`define IRQ_SRC_EXT0     4'h0
`define IRQ_SRC_USART2   4'h1
`define IRQ_SRC_CTR0     4'h2
`define IRQ_SRC_TWO_WIRE 4'h3
`define IRQ_SRC_EXT1     4'h4
`define IRQ_SRC_RSVD     4'h5
`define IRQ_SRC_CTR1     4'h6
`define IRQ_SRC_USB      4'h7
`define IRQ_SRC_USART1   4'h8
`define IRQ_SRC_CTR2     4'h9

// reset values
`define IRQ_RESET_VECTOR 4'h0
`define IRQ_RESET_FLAG   1'b0

// core clocks per machine cycle, external lines are sampled once per machine cycle
`define IRQ_MC_CLKS      12

`endif

// ---- irq_request_logic.sv ----
`timescale 1ns/10ps
`include "irq_regs.svh"
// Functional notes
// - ten request slots: two external lines, three counters, two-wire, USB, two USARTs, one reserved
// - external line zero requests on low level or falling transition per select
// - external line one requests on level or transition per its select
// - transition mode flags clear when the core vectors; level mode ones do not
// - level mode flag stays set while the line is held active
// - converter may take over the line one request on conversion done
// - counter 0/1 overflow sets its flag, except counter 0 in mode 3
// - counter 0/1 overflow flags clear in hardware when serviced
// - counter 2 overflow flag set by overflow, cleared by software only
// - counter 2 trigger pin edge, when enabled, sets external flag and requests
// - two-wire request follows its status flag; hardware clears it on service
// - USB request set by endpoint, suspend, resume and EOP events
// - per source rank; high routine never preempted, low preempted by high
// - equal rank ties resolved by fixed polling order, line zero first
// - per source enables plus a global enable that blocks all
// - each USART request is receive-done OR transmit-done, never hardware cleared
module irq_request_logic
	import irq_pkg::*;
#(
	parameter int MC_CLKS = `IRQ_MC_CLKS
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        ext_line_zero_in,
	input  wire logic        ext_line_one_in,
	input  wire logic        ext_zero_edge_sel_in,
	input  wire logic        ext_one_edge_sel_in,
	input  wire logic        conv_takeover_in,
	input  wire logic        conv_done_in,
	input  wire logic        counter0_overflow_in,
	input  wire logic        counter0_mode3_in,
	input  wire logic        counter1_overflow_in,
	input  wire logic        counter2_overflow_in,
	input  wire logic        counter2_ext_pin_in,
	input  wire logic        counter2_ext_enable_in,
	input  wire logic        counter2_ovf_clear_in,
	input  wire logic        counter2_ext_clear_in,
	input  wire logic        two_wire_req_flag_in,
	input  wire logic [6:0]  usb_event_in,
	input  wire logic        usb_flag_clear_in,
	input  wire logic        usart1_rx_done_flag_in,
	input  wire logic        usart1_tx_done_flag_in,
	input  wire logic        usart2_rx_done_flag_in,
	input  wire logic        usart2_tx_done_flag_in,
	input  wire irq_vec_type source_enable_in,
	input  wire logic        global_enable_bit_in,
	input  wire irq_vec_type rank_select_in,
	input  wire logic        core_ack_in,
	input  wire logic        core_reti_in,
	output logic             irq_req_out,
	output irq_idx_type      irq_vector_out,
	output logic             irq_rank_out,
	output logic             ext_zero_req_flag_out,
	output logic             ext_one_req_flag_out,
	output logic             counter0_overflow_flag_out,
	output logic             counter1_overflow_flag_out,
	output logic             counter2_overflow_flag_out,
	output logic             counter2_ext_flag_out,
	output logic             usb_req_flag_out,
	output logic             two_wire_clear_out
);
	if (MC_CLKS < 1 || MC_CLKS > 65536) begin : g_bad_mc
		$error("machine cycle length out of range");
	end

	// lowest set bit wins, so slot 0 is polled first
	function automatic logic [4:0] irq_pick(input irq_vec_type v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : irq_pick

	logic [15:0] mc_cnt;
	logic        tick;
	logic        taken;
	logic        c2x_meta;
	logic        c2x_sync;
	logic        c2x_prev;
	logic        c2x_fall;
	irq_vec_type pend;
	irq_vec_type ena;
	irq_vec_type hi_vec;
	irq_vec_type lo_vec;
	logic [4:0]  hi_pick;
	logic [4:0]  lo_pick;
	logic        allow_high;
	logic        allow_low;
	irq_svc_type svc;
	irq_svc_type next_svc;

	irq_ext_if ext0_if ();
	irq_ext_if ext1_if ();

	// machine cycle strobe
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mc_cnt <= 16'h0000;
		end else if (mc_cnt == 16'h0000) begin
			mc_cnt <= 16'(MC_CLKS - 1);
		end else begin
			mc_cnt <= mc_cnt - 16'h0001;
		end
	end
	assign tick  = (mc_cnt == 16'h0000);
	assign taken = core_ack_in & irq_req_out;

	assign ext0_if.pin       = ext_line_zero_in;
	assign ext0_if.edge_sel  = ext_zero_edge_sel_in;
	assign ext0_if.alt_sel   = 1'b0;
	assign ext0_if.alt_event = 1'b0;
	assign ext0_if.tick      = tick;
	assign ext0_if.taken     = taken && irq_vector_out == `IRQ_SRC_EXT0;
	assign ext1_if.pin       = ext_line_one_in;
	assign ext1_if.edge_sel  = ext_one_edge_sel_in;
	assign ext1_if.alt_sel   = conv_takeover_in;
	assign ext1_if.alt_event = conv_done_in;
	assign ext1_if.tick      = tick;
	assign ext1_if.taken     = taken && irq_vector_out == `IRQ_SRC_EXT1;

	irq_ext_line u_ext0 (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.ext     (ext0_if.line)
	);

	irq_ext_line u_ext1 (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.ext     (ext1_if.line)
	);

	assign ext_zero_req_flag_out = ext0_if.flag;
	assign ext_one_req_flag_out  = ext1_if.flag;

	// counter 0/1 flags; a new overflow beats the service clear
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			counter0_overflow_flag_out <= `IRQ_RESET_FLAG;
			counter1_overflow_flag_out <= `IRQ_RESET_FLAG;
		end else begin
			counter0_overflow_flag_out <= (counter0_overflow_in & ~counter0_mode3_in)
				| (counter0_overflow_flag_out & ~(taken && irq_vector_out == `IRQ_SRC_CTR0));
			counter1_overflow_flag_out <= counter1_overflow_in
				| (counter1_overflow_flag_out & ~(taken && irq_vector_out == `IRQ_SRC_CTR1));
		end
	end

	// trigger pin is asynchronous; c2x_meta feeds c2x_sync only
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			c2x_meta <= 1'b1;
			c2x_sync <= 1'b1;
			c2x_prev <= 1'b1;
		end else begin
			c2x_meta <= counter2_ext_pin_in;
			c2x_sync <= c2x_meta;
			c2x_prev <= c2x_sync;
		end
	end
	assign c2x_fall = c2x_prev & ~c2x_sync & counter2_ext_enable_in;

	// counter 2 flags are software cleared only, vectoring never touches them
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			counter2_overflow_flag_out <= `IRQ_RESET_FLAG;
			counter2_ext_flag_out      <= `IRQ_RESET_FLAG;
		end else begin
			counter2_overflow_flag_out <= counter2_overflow_in
				| (counter2_overflow_flag_out & ~counter2_ovf_clear_in);
			counter2_ext_flag_out <= c2x_fall
				| (counter2_ext_flag_out & ~counter2_ext_clear_in);
		end
	end

	// USB flag stays until software clears it
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			usb_req_flag_out <= `IRQ_RESET_FLAG;
		end else begin
			usb_req_flag_out <= (|usb_event_in) | (usb_req_flag_out & ~usb_flag_clear_in);
		end
	end

	// the two-wire unit owns its flag; we only pulse its clear
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			two_wire_clear_out <= 1'b0;
		end else begin
			two_wire_clear_out <= taken && irq_vector_out == `IRQ_SRC_TWO_WIRE;
		end
	end

	always_comb begin
		pend                       = '0;
		pend[`IRQ_SRC_EXT0]        = ext0_if.flag;
		pend[`IRQ_SRC_USART2]      = usart2_rx_done_flag_in | usart2_tx_done_flag_in;
		pend[`IRQ_SRC_CTR0]        = counter0_overflow_flag_out;
		pend[`IRQ_SRC_TWO_WIRE]    = two_wire_req_flag_in;
		pend[`IRQ_SRC_EXT1]        = ext1_if.flag;
		pend[`IRQ_SRC_CTR1]        = counter1_overflow_flag_out;
		pend[`IRQ_SRC_USB]         = usb_req_flag_out;
		pend[`IRQ_SRC_USART1]      = usart1_rx_done_flag_in | usart1_tx_done_flag_in;
		pend[`IRQ_SRC_CTR2]        = counter2_overflow_flag_out | counter2_ext_flag_out;
	end

	assign ena        = pend & source_enable_in & {`IRQ_NUM_SRC{global_enable_bit_in}};
	assign hi_vec     = ena & rank_select_in;
	assign lo_vec     = ena & ~rank_select_in;
	assign hi_pick    = irq_pick(hi_vec);
	assign lo_pick    = irq_pick(lo_vec);
	assign allow_high = (svc == SVC_IDLE) || (svc == SVC_LOW);
	assign allow_low  = (svc == SVC_IDLE);

	always_comb begin
		next_svc = svc;
		if (taken) begin
			unique case (svc)
				SVC_IDLE:     next_svc = irq_rank_out ? SVC_HIGH : SVC_LOW;
				SVC_LOW:      next_svc = SVC_LOW_HIGH;
				SVC_HIGH:     next_svc = SVC_HIGH;
				SVC_LOW_HIGH: next_svc = SVC_LOW_HIGH;
			endcase
		end else if (core_reti_in) begin
			unique case (svc)
				SVC_IDLE:     next_svc = SVC_IDLE;
				SVC_LOW:      next_svc = SVC_IDLE;
				SVC_HIGH:     next_svc = SVC_IDLE;
				SVC_LOW_HIGH: next_svc = SVC_LOW;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			svc <= SVC_IDLE;
		end else begin
			svc <= next_svc;
		end
	end

	// request is withdrawn for one cycle after a take so stale flags are not offered twice
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_req_out    <= 1'b0;
			irq_vector_out <= `IRQ_RESET_VECTOR;
			irq_rank_out   <= 1'b0;
		end else if (taken) begin
			irq_req_out <= 1'b0;
		end else if (allow_high && hi_pick[4]) begin
			irq_req_out    <= 1'b1;
			irq_vector_out <= hi_pick[3:0];
			irq_rank_out   <= 1'b1;
		end else if (allow_low && lo_pick[4]) begin
			irq_req_out    <= 1'b1;
			irq_vector_out <= lo_pick[3:0];
			irq_rank_out   <= 1'b0;
		end else begin
			irq_req_out <= 1'b0;
		end
	end

	a_ctr0_sets_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		counter0_overflow_in && !counter0_mode3_in |=> counter0_overflow_flag_out)
		else $error("counter 0 overflow did not set flag");

	a_ctr0_mode3_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
		!counter0_overflow_flag_out && counter0_mode3_in |=> !counter0_overflow_flag_out)
		else $error("counter 0 flag set in mode 3");

	a_ctr1_hw_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		taken && irq_vector_out == `IRQ_SRC_CTR1 && !counter1_overflow_in
		|=> !counter1_overflow_flag_out)
		else $error("counter 1 flag not cleared on service");

	a_ctr2_sw_only: assert property (@(posedge mclk_in) disable iff (rst_in)
		counter2_overflow_flag_out && !counter2_ovf_clear_in |=> counter2_overflow_flag_out)
		else $error("counter 2 flag cleared without software");

	a_ctr2_ext_edge: assert property (@(posedge mclk_in) disable iff (rst_in)
		c2x_prev && !c2x_sync && counter2_ext_enable_in |=> counter2_ext_flag_out)
		else $error("trigger edge did not set external flag");

	a_two_wire_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		taken && irq_vector_out == `IRQ_SRC_TWO_WIRE |=> two_wire_clear_out ##1 !two_wire_clear_out)
		else $error("two-wire clear pulse wrong");

	a_usb_event_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
		|usb_event_in |=> usb_req_flag_out)
		else $error("USB event lost");

	a_global_blocks: assert property (@(posedge mclk_in) disable iff (rst_in)
		!global_enable_bit_in |=> !irq_req_out)
		else $error("request offered while globally disabled");

	a_high_no_preempt: assert property (@(posedge mclk_in) disable iff (rst_in)
		(svc == SVC_HIGH || svc == SVC_LOW_HIGH) ##1 (svc == SVC_HIGH || svc == SVC_LOW_HIGH)
		|-> !irq_req_out)
		else $error("high rank routine preempted");

	a_poll_first: assert property (@(posedge mclk_in) disable iff (rst_in)
		!taken && allow_high && hi_vec[0] |=> irq_req_out && irq_vector_out == `IRQ_SRC_EXT0)
		else $error("polling order broken");

	a_usart_or: assert property (@(posedge mclk_in) disable iff (rst_in)
		!taken && allow_low && global_enable_bit_in && source_enable_in == 10'h100
		&& rank_select_in == 10'h000 && (usart1_rx_done_flag_in || usart1_tx_done_flag_in)
		|=> irq_req_out && irq_vector_out == `IRQ_SRC_USART1)
		else $error("USART request not raised");
endmodule : irq_request_logic

// ---- test_irq_request_logic.sv ----
`timescale 1ns/10ps
module test_irq_request_logic;
	import irq_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        pz = 1'b1, po = 1'b1, es0 = 1'b0, es1 = 1'b0, cto = 1'b0, cdn = 1'b0;
	logic        ov0 = 1'b0, m3 = 1'b0, ov1 = 1'b0, ov2 = 1'b0, xp = 1'b1, xen = 1'b0;
	logic        c2c = 1'b0, x2c = 1'b0, tw = 1'b0, usbc = 1'b0, reti = 1'b0, ack_en = 1'b0;
	logic        u1r = 1'b0, u1t = 1'b0, u2r = 1'b0, u2t = 1'b0, ga = 1'b0;
	logic [6:0]  usb = 7'h00;
	irq_vec_type en = 10'h000;
	irq_vec_type rk = 10'h000;
	logic        ack, req, rank, f0, f1, fc0, fc1, fc2, fx2, fusb, twc;
	irq_idx_type vec;
	logic [3:0]  tvec;
	logic [7:0]  cnt;
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #25 mclk_in = ~mclk_in;

	irq_request_logic #(.MC_CLKS(2)) DUT (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ext_line_zero_in(pz),
		.ext_line_one_in(po),
		.ext_zero_edge_sel_in(es0),
		.ext_one_edge_sel_in(es1),
		.conv_takeover_in(cto),
		.conv_done_in(cdn),
		.counter0_overflow_in(ov0),
		.counter0_mode3_in(m3),
		.counter1_overflow_in(ov1),
		.counter2_overflow_in(ov2),
		.counter2_ext_pin_in(xp),
		.counter2_ext_enable_in(xen),
		.counter2_ovf_clear_in(c2c),
		.counter2_ext_clear_in(x2c),
		.two_wire_req_flag_in(tw),
		.usb_event_in(usb),
		.usb_flag_clear_in(usbc),
		.usart1_rx_done_flag_in(u1r),
		.usart1_tx_done_flag_in(u1t),
		.usart2_rx_done_flag_in(u2r),
		.usart2_tx_done_flag_in(u2t),
		.source_enable_in(en),
		.global_enable_bit_in(ga),
		.rank_select_in(rk),
		.core_ack_in(ack),
		.core_reti_in(reti),
		.irq_req_out(req),
		.irq_vector_out(vec),
		.irq_rank_out(rank),
		.ext_zero_req_flag_out(f0),
		.ext_one_req_flag_out(f1),
		.counter0_overflow_flag_out(fc0),
		.counter1_overflow_flag_out(fc1),
		.counter2_overflow_flag_out(fc2),
		.counter2_ext_flag_out(fx2),
		.usb_req_flag_out(fusb),
		.two_wire_clear_out(twc)
	);

	irq_core_model core (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ack_en_in(ack_en),
		.req_in(req),
		.vector_in(vec),
		.ack_out(ack),
		.taken_vec_out(tvec),
		.taken_cnt_out(cnt)
	);

	task automatic wrap_up;
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : cyc

	// lets the core take one request, bounded wait
	task automatic take(input logic [3:0] exp);
		logic [7:0] n0;
		n0 = cnt;
		ack_en = 1'b1;
		for (int i = 0; i < 20 && cnt == n0; i++) cyc(1);
		ack_en = 1'b0;
		check("taken vector", {4'h0, tvec}, {4'h0, exp});
		check("taken count", cnt, n0 + 8'h01);
	endtask : take

	task automatic reti_p;
		reti = 1'b1;
		cyc(1);
		reti = 1'b0;
	endtask : reti_p

	task automatic s_counters;
		en = 10'h3FF;
		ga = 1'b1;
		ov0 = 1'b1;
		cyc(1);
		ov0 = 1'b0;
		cyc(2);
		check("ctr0 flag", 8'(fc0), 8'h01);
		check("ctr0 vector", 8'({req, vec}), 8'h12);
		take(4'h2);
		check("ctr0 flag cleared", 8'(fc0), 8'h00);
		reti_p();
		m3 = 1'b1;
		ov0 = 1'b1;
		cyc(1);
		ov0 = 1'b0;
		m3 = 1'b0;
		cyc(2);
		check("ctr0 mode3 flag", 8'(fc0), 8'h00);
		ov1 = 1'b1;
		cyc(1);
		ov1 = 1'b0;
		cyc(2);
		check("ctr1 flag", 8'(fc1), 8'h01);
		take(4'h6);
		check("ctr1 flag cleared", 8'(fc1), 8'h00);
		reti_p();
	endtask : s_counters

	task automatic s_poll;
		u1t = 1'b1;
		tw = 1'b1;
		u2r = 1'b1;
		cyc(3);
		check("poll first", 8'({req, vec}), 8'h11);
		en[1] = 1'b0;
		cyc(2);
		check("slot disable", 8'({req, vec}), 8'h13);
		ga = 1'b0;
		cyc(2);
		check("global off", 8'(req), 8'h00);
		ga = 1'b1;
		en[3] = 1'b0;
		cyc(2);
		check("usart1 tx", 8'({req, vec}), 8'h18);
		en = 10'h100;
		u1t = 1'b0;
		u1r = 1'b1;
		cyc(2);
		check("usart1 rx", 8'({req, vec}), 8'h18);
		u1r = 1'b0;
		u2r = 1'b0;
		tw = 1'b0;
		en = 10'h3FF;
		cyc(2);
		check("poll idle", 8'(req), 8'h00);
	endtask : s_poll

	// low routine, high preempts, high routine blocks all
	task automatic s_rank;
		rk = 10'h202;
		u1r = 1'b1;
		cyc(3);
		take(4'h8);
		cyc(2);
		check("low blocks low", 8'(req), 8'h00);
		u1r = 1'b0;
		ov2 = 1'b1;
		cyc(1);
		ov2 = 1'b0;
		cyc(2);
		check("preempt", 8'({req, rank, vec}), 8'h39);
		take(4'h9);
		u2t = 1'b1;
		cyc(3);
		check("high blocks all", 8'(req), 8'h00);
		reti_p();
		cyc(2);
		check("after pop", 8'({req, vec}), 8'h11);
		take(4'h1);
		u2t = 1'b0;
		check("ctr2 kept", 8'(fc2), 8'h01);
		c2c = 1'b1;
		cyc(1);
		c2c = 1'b0;
		cyc(1);
		check("ctr2 sw clear", 8'(fc2), 8'h00);
		reti_p();
		cyc(1);
		reti_p();
	endtask : s_rank

	// line zero at high rank so the first-polled slot is offered as high
	task automatic s_ext0;
		rk = 10'h001;
		es0 = 1'b1;
		pz = 1'b0;
		cyc(12);
		check("line0 fall", 8'(f0), 8'h01);
		check("line0 rank", 8'({req, rank, vec}), 8'h30);
		take(4'h0);
		check("line0 edge clr", 8'(f0), 8'h00);
		reti_p();
		cyc(8);
		check("line0 held low", 8'(f0), 8'h00);
		pz = 1'b1;
		cyc(8);
		es0 = 1'b0;
		pz = 1'b0;
		cyc(8);
		check("line0 level", 8'(f0), 8'h01);
		take(4'h0);
		check("line0 level kept", 8'(f0), 8'h01);
		pz = 1'b1;
		cyc(8);
		check("line0 released", 8'(f0), 8'h00);
		reti_p();
		cyc(4);
		check("no further", 8'(req), 8'h00);
	endtask : s_ext0

	task automatic s_ext1;
		po = 1'b0;
		cyc(8);
		check("line1 level", 8'({req, f1, vec}), 8'h34);
		po = 1'b1;
		cyc(8);
		check("line1 level off", 8'(f1), 8'h00);
		es1 = 1'b1;
		po = 1'b0;
		cyc(8);
		check("line1 fall", 8'(f1), 8'h01);
		take(4'h4);
		po = 1'b1;
		reti_p();
		cto = 1'b1;
		po = 1'b0;
		cyc(8);
		check("pin ignored", 8'(f1), 8'h00);
		cdn = 1'b1;
		cyc(1);
		cdn = 1'b0;
		cyc(2);
		check("conv done", 8'(f1), 8'h01);
		take(4'h4);
		reti_p();
		po = 1'b1;
		cyc(8);
		cto = 1'b0;
	endtask : s_ext1

	task automatic s_ctr2_usb;
		xp = 1'b0;
		cyc(6);
		check("trigger gated", 8'(fx2), 8'h00);
		xp = 1'b1;
		xen = 1'b1;
		cyc(4);
		xp = 1'b0;
		cyc(6);
		check("trigger", 8'({req, fx2, vec}), 8'h39);
		x2c = 1'b1;
		cyc(1);
		x2c = 1'b0;
		cyc(2);
		check("trigger clr", 8'(fx2), 8'h00);
		for (int b = 0; b < 7; b++) begin
			usb = 7'(1 << b);
			cyc(1);
			usb = 7'h00;
			cyc(2);
			check("usb event", 8'({req, fusb, vec}), 8'h37);
			usbc = 1'b1;
			cyc(1);
			usbc = 1'b0;
			cyc(2);
			check("usb clear", 8'(fusb), 8'h00);
		end
		tw = 1'b1;
		cyc(3);
		take(4'h3);
		check("two-wire clear", 8'(twc), 8'h01);
		cyc(1);
		check("two-wire clear end", 8'(twc), 8'h00);
		tw = 1'b0;
		reti_p();
	endtask : s_ctr2_usb

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end

	initial begin
		cyc(8);
		rst_in = 1'b0;
		s_counters();
		s_poll();
		s_rank();
		s_ext0();
		s_ext1();
		s_ctr2_usb();
		wrap_up();
	end
endmodule : test_irq_request_logic
